// ===== uoe_pkg.sv
// constants for the out endpoint and energy control block
`default_nettype none
package uoe_pkg;
  // indirect endpoint register indices
  localparam logic [7:0] OUT_CTL_LO_ADDR  = 8'h14;
  localparam logic [7:0] OUT_CTL_HI_ADDR  = 8'h15;
  localparam logic [7:0] OUT_CNT_LO_ADDR  = 8'h16;
  localparam logic [7:0] OUT_CNT_HI_ADDR  = 8'h17;
  localparam logic [7:0] IN_CTL_HI_ADDR   = 8'h12;
  // paged configuration register offsets
  localparam logic [7:0] ENERGY_CTL_ADDR  = 8'hB2;
  localparam logic [7:0] USB_CFG_ADDR     = 8'hB5;
  // control low bit positions
  localparam int CLR_TOG_BIT   = 7;
  localparam int STALL_SENT_BIT = 6;
  localparam int SEND_STALL_BIT = 5;
  localparam int FLUSH_BIT     = 4;
  localparam int DATA_ERR_BIT  = 3;
  localparam int OVERRUN_BIT   = 2;
  localparam int FIFO_FULL_BIT = 1;
  localparam int PKT_RDY_BIT   = 0;
  // control high and configuration bit positions
  localparam int DBL_BUF_BIT   = 7;
  localparam int ISO_BIT       = 6;
  localparam int FORCE_TOG_BIT = 3;
  localparam int SENSE_EN_BIT  = 7;
  localparam int SENSE_IE_BIT  = 6;
  localparam int SENSE_EV_BIT  = 5;
  localparam int LE_STAT_BIT   = 7;
  localparam int XCVR_MODE_BIT = 6;
  // reset values
  localparam logic [2:0] CLK_SEL_RESET = 3'h7;
  localparam logic [7:0] CFG_RESET     = 8'h07;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  // clock select encodings
  localparam logic [2:0] CLK_FAST      = 3'h0;
  localparam logic [2:0] CLK_FAST_DIV8 = 3'h1;
  localparam logic [2:0] CLK_EXT_DIV1  = 3'h2;
  localparam logic [2:0] CLK_EXT_DIV2  = 3'h3;
  localparam logic [2:0] CLK_EXT_DIV3  = 3'h4;
  // link handshake codes from the serial engine
  typedef enum logic [1:0] {
    UOE_HS_NONE  = 2'h0,
    UOE_HS_ACK   = 2'h1,
    UOE_HS_NAK   = 2'h3,
    UOE_HS_STALL = 2'h2
  } uoe_hs_t;
endpackage : uoe_pkg
`default_nettype wire

// ===== uoe_endpoint.sv
// out endpoint status, configuration and low energy control
//
// Notes on behaviour
// [R1] IN toggle flips only after an ACK when force-toggle is 0, after every send when 1.
// [R2] send-stall answers packets with STALL and sets stall-sent, except in isochronous mode.
// [R3] data-error flag is set on a crc or stuffing error only in isochronous mode.
// [R4] overrun flag sets when a packet is lost to a full fifo and holds until cleared.
// [R5] double-buffer enable, bit 7 of control high, resets 0 and sets fifo depth.
// [R6] isochronous bit, bit 6 of control high, selects isochronous against bulk.
// [R7] 10-bit received count is split low 8 and high 2 bits, valid while packet ready.
// [R8] sense enable routes the bus-power pin to sensing, otherwise it stays general use.
// [R9] bus-power interrupt needs its enable and the main usb enable.
// [R10] event flag sets on every change of the sensed bus-power level.
// [R11] 3-bit clock select resets to 7 and picks fast, fast/8, external /1 /2 /3.
// [R12] low energy status bit 7 reads 1 while in low energy mode.
// [R13] transceiver mode 0 lowers transceiver power in low energy mode, 1 leaves it.
// [R14] firmware should keep the 2-bit low energy clock field at 00.
// [R15] writing 1 to clear-toggle resets the out toggle to DATA0.
// [R16] writing 1 to flush drops the next packet, clears packet ready unless a second packet is held, then self clears.
`default_nettype none
module uoe_endpoint
  import uoe_pkg::*;
#(
  parameter int CNT_W = 10
)(
  // clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             RST_B,
  // register port: indirect endpoint and paged config
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  output logic      [7:0]       REG_RDATA,
  // received packets from the serial engine
  input  wire logic             RX_VALID,
  output logic                  RX_READY,
  input  wire logic [CNT_W-1:0] RX_COUNT,
  input  wire logic             RX_BAD,
  // firmware unloads packets
  output logic                  PKT_VALID,
  input  wire logic             PKT_READY,
  output logic      [CNT_W-1:0] PKT_COUNT,
  // handshake results
  output logic                  STALL_ANSWER,
  input  wire logic             IN_SENT,
  input  wire logic [1:0]       IN_HS,
  output logic                  IN_TOGGLE,
  output logic                  OUT_TOGGLE,
  input  wire logic             OUT_GOOD,
  // bus power and energy
  input  wire logic             BUS_POWER_PIN,
  input  wire logic             MAIN_IRQ_EN,
  input  wire logic             LOW_ENERGY_ACT,
  output logic                  BUS_POWER_IRQ,
  output logic                  GPIO_FREE,
  output logic                  XCVR_LOW_POWER,
  output logic      [2:0]       CLK_SELECT,
  output logic      [1:0]       LE_CLK_CTL
);

  // software-visible and internal state
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] aec_reg, aec_next;
  logic       dbl_reg, iso_reg, ftog_reg, stall_req_reg;
  logic       stall_sent_reg, derr_reg, ovr_reg, flush_reg;
  logic       in_tog_reg, out_tog_reg, pin_last_reg, irq_reg;
  logic       stall_out_reg;

  // two-entry packet buffer
  logic [CNT_W-1:0] buf_mem [2];
  logic             wptr_reg, rptr_reg;
  logic [1:0]       fill_reg;

  wire wr_lo  = REG_WR && (REG_ADDR == OUT_CTL_LO_ADDR);
  wire wr_hi  = REG_WR && (REG_ADDR == OUT_CTL_HI_ADDR);
  wire wr_inh = REG_WR && (REG_ADDR == IN_CTL_HI_ADDR);
  wire wr_cfg = REG_WR && (REG_ADDR == USB_CFG_ADDR);
  wire wr_aec = REG_WR && (REG_ADDR == ENERGY_CTL_ADDR);

  // [R5] depth one or two by double buffering
  wire [1:0] depth    = dbl_reg ? 2'h2 : 2'h1;
  wire       fifo_ful = (fill_reg >= depth);
  wire       pkt_rdy  = (fill_reg != 2'h0);
  // [R2] stall ignored on isochronous
  wire       stalling = stall_req_reg && !iso_reg;
  wire       rx_take  = RX_VALID && !stalling && !(iso_reg && RX_BAD);
  wire       rx_push  = rx_take && !fifo_ful;
  wire       pop      = pkt_rdy && (PKT_READY || flush_reg);
  // [R4] lost packet on full fifo
  wire       lost     = rx_take && fifo_ful;
  // [R8] sensed level only while enabled
  wire       sensed   = cfg_reg[SENSE_EN_BIT] & BUS_POWER_PIN;
  // [R10] edge of the sensed level
  wire       pin_edge = (sensed != pin_last_reg);
  wire [CNT_W-1:0] head = buf_mem[rptr_reg];
  // [R7] count split into two registers
  wire [7:0] cnt_lo = pkt_rdy ? head[7:0] : ZERO_BYTE;
  wire [7:0] cnt_hi = pkt_rdy ? {6'h00, head[CNT_W-1:8]} : ZERO_BYTE;

  // config next value, event set wins over write clear
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_cfg)
    begin
      cfg_next = {REG_WDATA[7:5], 2'h0, REG_WDATA[2:0]};
      cfg_next[SENSE_EV_BIT] = REG_WDATA[SENSE_EV_BIT] & cfg_reg[SENSE_EV_BIT];
    end
    if (pin_edge)
      cfg_next[SENSE_EV_BIT] = 1'b1;
  end

  // [R12] status tracks low energy; [R14] clock field kept as written
  always_comb
  begin
    aec_next = aec_reg;
    if (wr_aec)
      aec_next = {1'b0, REG_WDATA[6:4], 2'h0, REG_WDATA[1:0]};
    aec_next[LE_STAT_BIT] = LOW_ENERGY_ACT;
  end

  // read mux
  always_comb
  begin
    case (REG_ADDR)
      OUT_CTL_LO_ADDR: REG_RDATA = {1'b0, stall_sent_reg, stall_req_reg, flush_reg,
                                    derr_reg, ovr_reg, fifo_ful, pkt_rdy};
      OUT_CTL_HI_ADDR: REG_RDATA = {dbl_reg, iso_reg, 6'h00};
      OUT_CNT_LO_ADDR: REG_RDATA = cnt_lo;
      OUT_CNT_HI_ADDR: REG_RDATA = cnt_hi;
      IN_CTL_HI_ADDR:  REG_RDATA = {4'h0, ftog_reg, 3'h0};
      USB_CFG_ADDR:    REG_RDATA = cfg_reg;
      ENERGY_CTL_ADDR: REG_RDATA = aec_reg;
      default:         REG_RDATA = ZERO_BYTE;
    endcase
  end

  // configuration registers
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      cfg_reg <= CFG_RESET;
      aec_reg <= ZERO_BYTE;
    end
    else
    begin
      cfg_reg <= cfg_next;
      aec_reg <= aec_next;
    end
  end

  // endpoint control bits
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      dbl_reg       <= 1'b0;
      iso_reg       <= 1'b0;
      ftog_reg      <= 1'b0;
      stall_req_reg <= 1'b0;
      flush_reg     <= 1'b0;
    end
    else
    begin
      // [R6] isochronous select bit
      if (wr_hi)
      begin
        dbl_reg <= REG_WDATA[DBL_BUF_BIT];
        iso_reg <= REG_WDATA[ISO_BIT];
      end
      if (wr_inh)
        ftog_reg <= REG_WDATA[FORCE_TOG_BIT];
      if (wr_lo)
        stall_req_reg <= REG_WDATA[SEND_STALL_BIT];
      // [R16] flush self clears after one pop
      if (wr_lo && REG_WDATA[FLUSH_BIT])
        flush_reg <= 1'b1;
      else if (pop || !pkt_rdy)
        flush_reg <= 1'b0;
    end
  end

  // sticky flags: hardware set beats firmware clear
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      stall_sent_reg <= 1'b0;
      derr_reg       <= 1'b0;
      ovr_reg        <= 1'b0;
    end
    else
    begin
      // [R2] stall sent flag
      if (RX_VALID && stalling)
        stall_sent_reg <= 1'b1;
      else if (wr_lo && !REG_WDATA[STALL_SENT_BIT])
        stall_sent_reg <= 1'b0;
      // [R3] iso data error
      if (RX_VALID && iso_reg && RX_BAD)
        derr_reg <= 1'b1;
      else if (pop)
        derr_reg <= 1'b0;
      // [R4] overrun held until cleared
      if (lost)
        ovr_reg <= 1'b1;
      else if (wr_lo && !REG_WDATA[OVERRUN_BIT])
        ovr_reg <= 1'b0;
    end
  end

  // packet buffer
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      fill_reg <= 2'h0;
    end
    else
    begin
      if (rx_push)
        wptr_reg <= ~wptr_reg;
      if (pop)
        rptr_reg <= ~rptr_reg;
      fill_reg <= fill_reg + {1'b0, rx_push} - {1'b0, pop};
    end
  end

  // buffer storage
  always_ff @(posedge CORE_CLK)
  begin
    if (rx_push)
      buf_mem[wptr_reg] <= RX_COUNT;
  end

  // toggles, sensing and outputs
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      in_tog_reg    <= 1'b0;
      out_tog_reg   <= 1'b0;
      pin_last_reg  <= 1'b0;
      irq_reg       <= 1'b0;
      stall_out_reg <= 1'b0;
    end
    else
    begin
      // [R1] force toggle selection
      if (IN_SENT && (ftog_reg || IN_HS == UOE_HS_ACK))
        in_tog_reg <= ~in_tog_reg;
      // [R15] clear toggle wins over good packet
      if (wr_lo && REG_WDATA[CLR_TOG_BIT])
        out_tog_reg <= 1'b0;
      else if (OUT_GOOD)
        out_tog_reg <= ~out_tog_reg;
      pin_last_reg  <= sensed;
      // [R9] both enables required
      irq_reg       <= cfg_reg[SENSE_EV_BIT] && cfg_reg[SENSE_IE_BIT] && MAIN_IRQ_EN;
      stall_out_reg <= RX_VALID && stalling;
    end
  end

  // output drive; ready and valid lines stay combinational so flow needs no extra cycle
  assign RX_READY       = !fifo_ful || stalling;
  assign PKT_VALID      = pkt_rdy && !flush_reg;
  assign PKT_COUNT      = head;
  assign STALL_ANSWER   = stall_out_reg;
  assign IN_TOGGLE      = in_tog_reg;
  assign OUT_TOGGLE     = out_tog_reg;
  assign BUS_POWER_IRQ  = irq_reg;
  // [R8] pin free when sensing is off
  assign GPIO_FREE      = !cfg_reg[SENSE_EN_BIT];
  // [R13] transceiver power
  assign XCVR_LOW_POWER = aec_reg[LE_STAT_BIT] && !aec_reg[XCVR_MODE_BIT];
  // [R11] clock select field
  assign CLK_SELECT     = cfg_reg[2:0];
  assign LE_CLK_CTL     = aec_reg[5:4];

  // assertions
  // stall steps: a packet meets send-stall, then flag and handshake follow
  sequence stall_hit_s;
    RX_VALID && stalling;
  endsequence
  sequence stall_seen_s;
    stall_sent_reg && STALL_ANSWER;
  endsequence

  // [R4] lost packet sets overrun
  overrun_set_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
    lost |=> ovr_reg)
    else $error("overrun not set");
  // [R4] overrun holds until cleared
  overrun_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
    ovr_reg && !wr_lo |=> ovr_reg)
    else $error("overrun dropped");
  // [R9] no irq without enable
  irq_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R9]
    !cfg_reg[SENSE_IE_BIT] |=> !BUS_POWER_IRQ)
    else $error("irq without enable");
  // [R9] no irq without main enable
  irq_main_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R9]
    !MAIN_IRQ_EN |=> !BUS_POWER_IRQ)
    else $error("irq without main enable");
  // [R10] edge sets flag
  sense_edge_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R10]
    pin_edge |=> cfg_reg[SENSE_EV_BIT])
    else $error("event flag missed");
  // [R2] stall sent
  stall_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2]
    stall_hit_s |=> stall_seen_s)
    else $error("stall not flagged");
  // [R2] sent flag holds until cleared
  stall_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2]
    stall_sent_reg && !wr_lo |=> stall_sent_reg)
    else $error("stall flag dropped");
  // [R2] no stall on isochronous
  iso_stall_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2]
    RX_VALID && iso_reg |=> !STALL_ANSWER)
    else $error("stall on isochronous");
  // [R3] error flag only iso
  iso_error_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R3]
    !iso_reg && !derr_reg |=> !derr_reg)
    else $error("data error outside iso");
  // [R1] no flip without ack unless forced
  in_toggle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
    IN_SENT && !ftog_reg && IN_HS != UOE_HS_ACK |=> $stable(in_tog_reg))
    else $error("toggle flipped without ack");
  // [R1] forced toggle flips on every send
  in_force_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
    IN_SENT && ftog_reg |=> in_tog_reg != $past(in_tog_reg))
    else $error("forced toggle missed");
  // [R15] clear toggle
  out_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R15]
    wr_lo && REG_WDATA[CLR_TOG_BIT] |=> !out_tog_reg)
    else $error("toggle not cleared");
  // [R5] single buffer never holds two
  single_depth_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R5]
    !dbl_reg && fill_reg == 2'h1 && !pop |=> fill_reg == 2'h1)
    else $error("depth exceeded");
  // [R7] first packet into empty buffer shows its count
  head_count_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R7]
    rx_push && !pkt_rdy |=> PKT_COUNT == $past(RX_COUNT))
    else $error("head count wrong");

endmodule : uoe_endpoint
`default_nettype wire

// ===== uoe_host_model.sv
// serial engine model that hands received packets to the endpoint
`default_nettype none
module uoe_host_model (
  // clock
  input  wire logic       clk,
  // packet handoff
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [9:0]      rx_count,
  output logic            rx_bad
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle lines
  initial
  begin
    rx_valid = 1'b0;
    rx_count = 10'h2AA;
    rx_bad   = 1'b0;
  end

  // hold the offer until taken; once forces a single-edge offer into a full fifo
  task automatic send(input logic [9:0] cnt, input logic bad, input logic once,
                      output logic taken);
    logic ok;
    int   n;
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_count = cnt;
    rx_bad   = bad;
    ok       = 1'b0;
    for (n = 0; n < 40 && !ok; n++)
    begin
      #6;
      ok = rx_ready | once;
      @(posedge clk);
    end
    #1;
    // released lines show the inverse so stale data cannot pass
    rx_valid = 1'b0;
    rx_count = ~cnt;
    rx_bad   = ~bad;
    taken    = ok;
  endtask : send
endmodule : uoe_host_model
`default_nettype wire

// ===== usb_out_endpoint_and_energy_control_bench.sv
// self-checking bench for the out endpoint and energy control block
`default_nettype none
module usb_out_endpoint_and_energy_control_bench;
  import uoe_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // design signals
  logic       CORE_CLK = 1'b0;
  logic       RST_B, REG_WR, REG_RD, RX_VALID, RX_READY, RX_BAD, PKT_VALID, PKT_READY;
  logic       STALL_ANSWER, IN_SENT, IN_TOGGLE, OUT_TOGGLE, OUT_GOOD, BUS_POWER_PIN;
  logic       MAIN_IRQ_EN, LOW_ENERGY_ACT, BUS_POWER_IRQ, GPIO_FREE, XCVR_LOW_POWER;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [9:0] RX_COUNT, PKT_COUNT, c;
  logic [1:0] IN_HS, LE_CLK_CTL;
  logic [2:0] CLK_SELECT;
  // bookkeeping
  int          errors = 0, comparisons = 0, stalls = 0, i;
  logic [9:0]  q[$];
  logic [31:0] seed = 32'hFB0D;

  always #4 CORE_CLK = ~CORE_CLK;

  uoe_endpoint i_uoe_endpoint (.CORE_CLK, .RST_B, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
    .REG_RDATA, .RX_VALID, .RX_READY, .RX_COUNT, .RX_BAD, .PKT_VALID, .PKT_READY, .PKT_COUNT,
    .STALL_ANSWER, .IN_SENT, .IN_HS, .IN_TOGGLE, .OUT_TOGGLE, .OUT_GOOD, .BUS_POWER_PIN,
    .MAIN_IRQ_EN, .LOW_ENERGY_ACT, .BUS_POWER_IRQ, .GPIO_FREE, .XCVR_LOW_POWER, .CLK_SELECT,
    .LE_CLK_CTL);
  uoe_host_model i_uoe_host_model (.clk(CORE_CLK), .rx_ready(RX_READY), .rx_valid(RX_VALID),
    .rx_count(RX_COUNT), .rx_bad(RX_BAD));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic step(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    #1;
    REG_WR    = 1'b1;
    REG_ADDR  = a;
    REG_WDATA = d;
    step(1);
    REG_WR    = 1'b0;
  endtask : wr

  // read data is combinational, so sample it once the address has settled
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    step(1);
    REG_RD   = 1'b1;
    REG_ADDR = a;
    #2;
    chk("reg_read", REG_RDATA, exp);
    REG_RD   = 1'b0;
  endtask : rd

  task automatic in_pkt(input uoe_hs_t hs, input logic exp);
    step(1);
    IN_SENT = 1'b1;
    IN_HS   = hs;
    step(1);
    IN_SENT = 1'b0;
    IN_HS   = UOE_HS_NONE;
    step(1);
    chk("in_toggle", IN_TOGGLE, exp);
  endtask : in_pkt

  // random count; keep notes it for the unload watcher
  task automatic pkt(input logic bad, input logic once, input logic keep);
    logic took;
    seed = lfsr(seed);
    c    = seed[9:0];
    if (keep)
      q.push_back(c);
    i_uoe_host_model.send(c, bad, once, took);
    // an offer never taken counts as a mismatch and ends the run
    chk("rx_taken", 16'(took), 16'h1);
    if (took !== 1'b1)
      final_report();
  endtask : pkt

  // a timed-out drain counts as a mismatch
  task automatic drain();
    for (int n = 0; n < 60 && q.size() > 0; n++)
      @(posedge CORE_CLK);
    if (q.size() > 0)
    begin
      chk("drain_wait", 16'(q.size()), 16'h0);
      final_report();
    end
    step(1);
  endtask : drain

  // compare each unloaded packet with the oldest note
  always @(posedge CORE_CLK)
    if (RST_B === 1'b1 && PKT_VALID === 1'b1 && PKT_READY === 1'b1)
    begin
      if (q.size() == 0)
        chk("pkt_extra", 16'h1, 16'h0);
      else
        chk("pkt_count", PKT_COUNT, q.pop_front());
    end

  // count stall handshakes
  always @(posedge CORE_CLK)
    if (STALL_ANSWER === 1'b1)
      stalls++;

  // main sequence
  initial
  begin
    {RST_B, REG_WR, REG_RD, REG_ADDR, REG_WDATA, PKT_READY, IN_SENT, OUT_GOOD} = '0;
    {IN_HS, BUS_POWER_PIN, MAIN_IRQ_EN, LOW_ENERGY_ACT} = '0;
    step(6);
    RST_B = 1'b1;
    rd(USB_CFG_ADDR, CFG_RESET);
    rd(OUT_CTL_LO_ADDR, ZERO_BYTE);
    rd(OUT_CTL_HI_ADDR, ZERO_BYTE);
    rd(OUT_CNT_HI_ADDR, ZERO_BYTE);
    rd(ENERGY_CTL_ADDR, ZERO_BYTE);
    rd(8'h40, ZERO_BYTE);
    for (i = 0; i < 5; i++)
    begin
      wr(USB_CFG_ADDR, 8'(i));
      chk("clk_sel", CLK_SELECT, 16'(i));
    end
    chk("gpio_free", GPIO_FREE, 16'h1);
    wr(USB_CFG_ADDR, 8'hC0);
    chk("gpio_free", GPIO_FREE, 16'h0);
    BUS_POWER_PIN = 1'b1;
    step(4);
    rd(USB_CFG_ADDR, 8'hE0);
    chk("irq", BUS_POWER_IRQ, 16'h0);
    MAIN_IRQ_EN = 1'b1;
    step(2);
    chk("irq", BUS_POWER_IRQ, 16'h1);
    wr(USB_CFG_ADDR, 8'h80);
    BUS_POWER_PIN = 1'b0;
    step(4);
    rd(USB_CFG_ADDR, 8'hA0);
    chk("irq", BUS_POWER_IRQ, 16'h0);
    LOW_ENERGY_ACT = 1'b1;
    step(2);
    rd(ENERGY_CTL_ADDR, 8'h80);
    chk("xcvr", XCVR_LOW_POWER, 16'h1);
    // firmware keeps the low energy clock field at 00
    wr(ENERGY_CTL_ADDR, 8'h40);
    rd(ENERGY_CTL_ADDR, 8'hC0);
    chk("xcvr", XCVR_LOW_POWER, 16'h0);
    chk("le_clk", LE_CLK_CTL, 16'h0);
    in_pkt(UOE_HS_NAK, 1'b0);
    in_pkt(UOE_HS_ACK, 1'b1);
    wr(IN_CTL_HI_ADDR, 8'h08);
    in_pkt(UOE_HS_NAK, 1'b0);
    OUT_GOOD = 1'b1;
    step(1);
    OUT_GOOD = 1'b0;
    step(1);
    chk("out_toggle", OUT_TOGGLE, 16'h1);
    wr(OUT_CTL_LO_ADDR, 8'h80);
    chk("out_toggle", OUT_TOGGLE, 16'h0);
    // single buffer fills with one packet, double with two
    pkt(1'b0, 1'b0, 1'b1);
    rd(OUT_CTL_LO_ADDR, 8'h03);
    chk("rx_ready", RX_READY, 16'h0);
    chk("pkt_valid", PKT_VALID, 16'h1);
    rd(OUT_CNT_LO_ADDR, c[7:0]);
    rd(OUT_CNT_HI_ADDR, {6'h0, c[9:8]});
    wr(OUT_CTL_HI_ADDR, 8'h80);
    rd(OUT_CTL_HI_ADDR, 8'h80);
    rd(OUT_CTL_LO_ADDR, 8'h01);
    pkt(1'b0, 1'b0, 1'b1);
    rd(OUT_CTL_LO_ADDR, 8'h03);
    pkt(1'b0, 1'b1, 1'b0);
    rd(OUT_CTL_LO_ADDR, 8'h07);
    wr(OUT_CTL_LO_ADDR, 8'h00);
    rd(OUT_CTL_LO_ADDR, 8'h03);
    wr(OUT_CTL_LO_ADDR, 8'h10);
    void'(q.pop_front());
    rd(OUT_CTL_LO_ADDR, 8'h01);
    PKT_READY = 1'b1;
    for (i = 0; i < 3; i++)
      pkt(1'b0, 1'b0, 1'b1);
    drain();
    rd(OUT_CNT_LO_ADDR, ZERO_BYTE);
    wr(OUT_CTL_LO_ADDR, 8'h20);
    pkt(1'b0, 1'b0, 1'b0);
    step(3);
    chk("stalls", 16'(stalls), 16'h1);
    rd(OUT_CTL_LO_ADDR, 8'h60);
    // isochronous ignores stall and flags bad packets
    wr(OUT_CTL_HI_ADDR, 8'h40);
    rd(OUT_CTL_HI_ADDR, 8'h40);
    wr(OUT_CTL_LO_ADDR, 8'h20);
    pkt(1'b0, 1'b0, 1'b1);
    drain();
    chk("stalls", 16'(stalls), 16'h1);
    pkt(1'b1, 1'b0, 1'b0);
    rd(OUT_CTL_LO_ADDR, 8'h28);
    final_report();
  end
endmodule : usb_out_endpoint_and_energy_control_bench
`default_nettype wire
